// ===== rtl/nrc_pkg.sv
// package: opcodes, id bytes, parameter page head, timing
package nrc_pkg;
  localparam logic [7:0] NRC_OP_RESET      = 8'hff;
  localparam logic [7:0] NRC_OP_SYNC_RESET = 8'hfc;
  localparam logic [7:0] NRC_OP_DIE_RESET  = 8'hfa;
  localparam logic [7:0] NRC_OP_IDENTIFY   = 8'h90;
  localparam logic [7:0] NRC_OP_PARAM_PAGE = 8'hec;
  localparam logic [7:0] NRC_OP_STATUS     = 8'h70;
  localparam logic [7:0] NRC_OP_STATUS_ADR = 8'h78;
  localparam logic [7:0] NRC_ADR_MAKER     = 8'h00;
  localparam logic [7:0] NRC_ADR_SIG       = 8'h20;
  // identification codes: values are arbitrary
  localparam logic [7:0] NRC_ID_MAKER  = 8'h5a;
  localparam logic [7:0] NRC_ID_DEVICE = 8'h11;
  localparam logic [7:0] NRC_ID_BYTE2  = 8'h00;
  localparam logic [7:0] NRC_ID_BYTE3  = 8'h22;
  localparam logic [7:0] NRC_ID_BYTE4  = 8'h33;
  localparam int         NRC_ID_LEN    = 5;
  // signature letters
  localparam logic [7:0] NRC_SIG0 = 8'h4f;
  localparam logic [7:0] NRC_SIG1 = 8'h4e;
  localparam logic [7:0] NRC_SIG2 = 8'h46;
  localparam logic [7:0] NRC_SIG3 = 8'h49;
  // parameter page bytes 4..9
  localparam logic [7:0] NRC_PP_REV_LO    = 8'h1e;
  localparam logic [7:0] NRC_PP_REV_HI    = 8'h00;
  localparam logic [7:0] NRC_PP_FEAT_ASYN = 8'h58;
  localparam logic [7:0] NRC_PP_FEAT_SYNC = 8'h78;
  localparam logic [7:0] NRC_PP_FEAT_HI   = 8'h01;
  localparam logic [7:0] NRC_PP_OPT_LO    = 8'hff;
  localparam logic [7:0] NRC_PP_OPT_HI    = 8'h03;
  localparam logic [7:0] NRC_PP_LAST      = 8'd9;
  localparam logic [7:0] NRC_TM_ASYNC0    = 8'h00;
  localparam int         NRC_DIES         = 2;
  // timing
  localparam int CLK_MHZ              = 100;
  localparam int RESET_TIME_NS        = 5000;
  localparam int INTERFACE_CHANGE_NS  = 1000;
  localparam int RESET_CYC  = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ITC_CYC    = (INTERFACE_CHANGE_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    NRC_OUT_NONE  = 3'b001,
    NRC_OUT_ID    = 3'b010,
    NRC_OUT_PAGE  = 3'b100
  } nrc_out_t;
endpackage

// ===== rtl/nrc_if.sv
// interface between top and busy timers
`timescale 1ns/100ps
interface nrc_timer_if;
  logic [nrc_pkg::NRC_DIES-1:0] start;
  logic [nrc_pkg::NRC_DIES-1:0] busy;
  modport ctl (output start, input busy);
  modport tmr (input start, output busy);
endinterface

// ===== rtl/nrc_busy_timer.sv
// per-die reset busy timers
`timescale 1ns/100ps
module nrc_busy_timer
  import nrc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // control
  nrc_timer_if.tmr  tif
);
  genvar g;
  generate
    for (g = 0; g < NRC_DIES; g++) begin : g_die
      logic [15:0] cnt_r;
      // restartable down counter, busy while nonzero
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          cnt_r <= 16'h0000;
        end else if (tif.start[g]) begin
          cnt_r <= 16'(RESET_CYC);
        end else if (cnt_r != 16'h0000) begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
      assign tif.busy[g] = (cnt_r != 16'h0000);
    end
  endgenerate
endmodule

// ===== rtl/nrc_top.sv
// reset and identification command handling of a nand target
`timescale 1ns/100ps
module nrc_top
  import nrc_pkg::*;
#(
  parameter logic SYNC_CAPABLE = 1'b1
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // nand pins
  input  wire logic                target_sel_n,
  input  wire logic                cmd_latch_en,
  input  wire logic                addr_latch_en,
  input  wire logic                write_clk,
  input  wire logic                read_strobe_n,
  input  wire logic [7:0]          dq_in,
  output logic      [7:0]          dq_out,
  output logic                     dq_oe,
  input  wire logic                dqs_in,
  output logic                     dqs_out,
  output logic                     dqs_oe,
  output logic                     ready_busy_n,
  // interface state
  input  wire logic                set_sync_mode,
  input  wire logic [7:0]          set_timing_mode,
  output logic                     sync_active,
  output logic      [7:0]          feature_param_one,
  output logic                     data_invalid,
  output logic                     abort_ops,
  output logic [nrc_pkg::NRC_DIES-1:0] die_busy
);
  import nrc_pkg::*;

  logic [1:0]          cs_s, cl_s, al_s, wc_s, re_s, ds_s;
  logic [7:0]          dq_s1, dq_s2;
  logic                wc_d, re_d, ds_d;
  logic                sync_r, sync_nxt;
  logic [7:0]          tm_r;
  nrc_out_t            out_r;
  logic [7:0]          idx_r;
  logic [7:0]          adr_r;
  logic                await_adr_r;
  logic [7:0]          last_op_r;
  logic [2:0]          die_adr_cnt_r;
  logic [15:0]         itc_r;
  logic [7:0]          out_byte;
  logic                we_edge, re_edge, ds_rise, ds_fall, cmd_cyc, adr_cyc;
  logic                any_busy, itc_busy;
  logic [NRC_DIES-1:0] start_w;
  nrc_timer_if         tif();

  // id and page byte lookup
  function automatic logic [7:0] nrc_byte(input nrc_out_t m, input logic [7:0] a,
                                          input logic [7:0] i, input logic sc);
    logic [7:0] b;
    b = 8'h00;
    if (m == NRC_OUT_ID && a == NRC_ADR_MAKER) begin
      unique case (i)
        8'd0: b = NRC_ID_MAKER;
        8'd1: b = NRC_ID_DEVICE;
        8'd2: b = NRC_ID_BYTE2;
        8'd3: b = NRC_ID_BYTE3;
        8'd4: b = NRC_ID_BYTE4;
        default: b = 8'h00;
      endcase
    end else begin
      unique case (i)
        8'd0: b = NRC_SIG0;
        8'd1: b = NRC_SIG1;
        8'd2: b = NRC_SIG2;
        8'd3: b = NRC_SIG3;
        8'd4: b = (m == NRC_OUT_PAGE) ? NRC_PP_REV_LO : 8'h00;
        8'd5: b = (m == NRC_OUT_PAGE) ? NRC_PP_REV_HI : 8'h00;
        8'd6: b = (m == NRC_OUT_PAGE) ? (sc ? NRC_PP_FEAT_SYNC : NRC_PP_FEAT_ASYN) : 8'h00;
        8'd7: b = (m == NRC_OUT_PAGE) ? NRC_PP_FEAT_HI : 8'h00;
        8'd8: b = (m == NRC_OUT_PAGE) ? NRC_PP_OPT_LO : 8'h00;
        8'd9: b = (m == NRC_OUT_PAGE) ? NRC_PP_OPT_HI : 8'h00;
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  // two-stage synchronisers for all pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_s  <= 2'b11;
      cl_s  <= 2'b00;
      al_s  <= 2'b00;
      wc_s  <= 2'b11;
      re_s  <= 2'b11;
      ds_s  <= 2'b00;
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      cs_s  <= {cs_s[0], target_sel_n};
      cl_s  <= {cl_s[0], cmd_latch_en};
      al_s  <= {al_s[0], addr_latch_en};
      wc_s  <= {wc_s[0], write_clk};
      re_s  <= {re_s[0], read_strobe_n};
      ds_s  <= {ds_s[0], dqs_in};
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wc_d <= 1'b1;
      re_d <= 1'b1;
      ds_d <= 1'b0;
    end else begin
      wc_d <= wc_s[1];
      re_d <= re_s[1];
      ds_d <= ds_s[1];
    end
  end

  // latch on write-enable rise (async) or clock rise (sync); no free-running clock needed
  assign we_edge  = wc_s[1] & ~wc_d & ~cs_s[1];
  assign cmd_cyc  = we_edge & cl_s[1] & ~al_s[1] & (~sync_r | ~re_s[1] | 1'b1);
  assign adr_cyc  = we_edge & al_s[1] & ~cl_s[1];
  // end of a read strobe toggle: the byte shown during the low phase is consumed
  assign re_edge  = re_s[1] & ~re_d & ~cs_s[1] & ~sync_r;
  assign ds_rise  = ds_s[1] & ~ds_d & ~cs_s[1] & sync_r & cl_s[1] & al_s[1];
  assign ds_fall  = ~ds_s[1] & ds_d & ~cs_s[1] & sync_r;
  assign any_busy = |tif.busy;
  assign itc_busy = (itc_r != 16'h0000);
  assign out_byte = nrc_byte(out_r, adr_r, idx_r, SYNC_CAPABLE);

  // timer starts: full and sync reset hit all dies, die reset only its own
  always_comb begin
    start_w = '0;
    if (cmd_cyc && dq_s2 == NRC_OP_RESET) begin
      start_w = '1;
    end else if (cmd_cyc && dq_s2 == NRC_OP_SYNC_RESET && sync_r && !itc_busy) begin
      start_w = '1;
    end else if (adr_cyc && last_op_r == NRC_OP_DIE_RESET && die_adr_cnt_r == 3'd2) begin
      start_w[dq_s2[0]] = 1'b1;
    end
  end
  assign tif.start = start_w;

  nrc_busy_timer u_timer (
    .clk   (clk),
    .reset (reset),
    .tif   (tif)
  );

  // interface type: full reset drops to async, others keep it
  always_comb begin
    sync_nxt = sync_r;
    if (cmd_cyc && dq_s2 == NRC_OP_RESET) begin
      sync_nxt = 1'b0;
    end else if (set_sync_mode && SYNC_CAPABLE) begin
      sync_nxt = 1'b1;
    end
  end

  // interface and timing mode state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_r <= 1'b0;
      tm_r   <= NRC_TM_ASYNC0;
    end else begin
      sync_r <= sync_nxt;
      if (cmd_cyc && dq_s2 == NRC_OP_RESET && sync_r) begin
        tm_r <= NRC_TM_ASYNC0;
      end else if (set_sync_mode && SYNC_CAPABLE) begin
        tm_r <= set_timing_mode;
      end
      // async full reset keeps tm_r
    end
  end

  // interface change window after full reset in sync mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      itc_r <= 16'h0000;
    end else if (cmd_cyc && dq_s2 == NRC_OP_RESET && sync_r) begin
      itc_r <= 16'(ITC_CYC);
    end else if (itc_busy) begin
      itc_r <= itc_r - 16'h0001;
    end
  end

  // command register, address capture and output mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_op_r     <= 8'h00;
      await_adr_r   <= 1'b0;
      adr_r         <= 8'h00;
      out_r         <= NRC_OUT_NONE;
      die_adr_cnt_r <= 3'd0;
    end else if (cmd_cyc) begin
      if (dq_s2 == NRC_OP_RESET || dq_s2 == NRC_OP_SYNC_RESET) begin
        last_op_r   <= 8'h00;
        await_adr_r <= 1'b0;
        out_r       <= NRC_OUT_NONE;
      end else if (itc_busy) begin
        if (dq_s2 == NRC_OP_STATUS || dq_s2 == NRC_OP_STATUS_ADR) begin
          last_op_r <= dq_s2;
          out_r     <= NRC_OUT_NONE;
        end
      end else if (dq_s2 == NRC_OP_DIE_RESET) begin
        last_op_r     <= dq_s2;
        die_adr_cnt_r <= 3'd0;
        out_r         <= NRC_OUT_NONE;
      end else if ((dq_s2 == NRC_OP_IDENTIFY || dq_s2 == NRC_OP_PARAM_PAGE) && !any_busy) begin
        last_op_r   <= dq_s2;
        await_adr_r <= 1'b1;
        out_r       <= (dq_s2 == NRC_OP_IDENTIFY) ? NRC_OUT_ID : NRC_OUT_PAGE;
      end else if (dq_s2 != NRC_OP_IDENTIFY && dq_s2 != NRC_OP_PARAM_PAGE) begin
        last_op_r <= dq_s2;
        out_r     <= NRC_OUT_NONE;
      end
    end else if (adr_cyc) begin
      if (await_adr_r) begin
        adr_r       <= dq_s2;
        await_adr_r <= 1'b0;
      end
      if (last_op_r == NRC_OP_DIE_RESET) begin
        die_adr_cnt_r <= die_adr_cnt_r + 3'd1;
      end
    end
  end

  // byte index: restarts on address, advances after each byte has been shown
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_r <= 8'h00;
    end else if (adr_cyc || cmd_cyc) begin
      idx_r <= 8'h00;
    end else if ((re_edge || (ds_fall && cl_s[1] && al_s[1])) && out_r != NRC_OUT_NONE && idx_r != 8'hff) begin
      idx_r <= idx_r + 8'h01;
    end
  end

  // data pins: byte held for rising and falling strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dq_out  <= 8'h00;
      dq_oe   <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe  <= 1'b0;
    end else begin
      dq_out  <= out_byte;
      dq_oe   <= (out_r != NRC_OUT_NONE) && !cs_s[1] && !await_adr_r &&
                 (sync_r ? (cl_s[1] & al_s[1]) : !re_s[1]);
      dqs_out <= ds_rise ? 1'b1 : (ds_fall ? 1'b0 : dqs_out);
      dqs_oe  <= sync_r && (out_r != NRC_OUT_NONE) && !cs_s[1];
    end
  end

  // status outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready_busy_n      <= 1'b1;
      sync_active       <= 1'b0;
      feature_param_one <= NRC_TM_ASYNC0;
      data_invalid      <= 1'b0;
      abort_ops         <= 1'b0;
      die_busy          <= '0;
    end else begin
      ready_busy_n      <= !any_busy && !(|start_w);
      sync_active       <= sync_r;
      feature_param_one <= tm_r;
      abort_ops         <= |start_w;
      if (|start_w) begin
        data_invalid <= 1'b1;
      end else if (set_sync_mode) begin
        data_invalid <= 1'b0;
      end
      die_busy          <= tif.busy | start_w;
    end
  end
endmodule

// ===== verif/nrc_top_chk.sv
// assertion checker for the nand reset and identification block
`timescale 1ns/100ps
module nrc_top_chk
  import nrc_pkg::*;
(
  // clock and reset
  input logic                clk,
  input logic                reset,
  // watched outputs
  input logic                ready_busy_n,
  input logic                abort_ops,
  input logic                data_invalid,
  input logic                dq_oe,
  input logic                dqs_oe,
  input logic                sync_active,
  input logic [7:0]          feature_param_one,
  input logic [NRC_DIES-1:0] die_busy
);
  localparam int LO = RESET_CYC - 1;
  localparam int HI = RESET_CYC + 2;
  int lo_cnt_r;
  int ab_cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // length of the current busy period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) lo_cnt_r <= 0;
    else lo_cnt_r <= ready_busy_n ? 0 : lo_cnt_r + 1;
  end
  // cycles since the last accepted reset, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) ab_cnt_r <= 99;
    else ab_cnt_r <= abort_ops ? 0 : (ab_cnt_r < 99 ? ab_cnt_r + 1 : 99);
  end
  sequence busy_start_s; $fell(ready_busy_n); endsequence
  sequence to_async_s; $fell(sync_active); endsequence
  sequence back_ready_s; ##[0:HI] (ready_busy_n && feature_param_one == NRC_TM_ASYNC0); endsequence
  rb_follows_a: assert property ((|die_busy) |-> ##[0:2] !ready_busy_n)
    else $error("die busy without ready low");
  busy_min_a: assert property (busy_start_s |-> !ready_busy_n [*8])
    else $error("busy period too short");
  busy_len_a: assert property ($rose(ready_busy_n) |-> (lo_cnt_r >= LO && lo_cnt_r <= HI))
    else $error("busy period length wrong");
  abort_pulse_a: assert property (abort_ops |=> !abort_ops)
    else $error("abort longer than one cycle");
  abort_inval_a: assert property (abort_ops |-> ##[0:2] data_invalid)
    else $error("reset left data valid");
  abort_oe_a: assert property (abort_ops |-> ##[1:4] !dq_oe)
    else $error("output kept after reset");
  abort_cause_a: assert property ($rose(|die_busy) |-> (ab_cnt_r <= 4) or ##[0:4] abort_ops)
    else $error("die busy without a reset");
  to_async_a: assert property (to_async_s |-> ##[0:2] !ready_busy_n)
    else $error("interface left sync outside reset");
  tm_zero_a: assert property (to_async_s |-> back_ready_s)
    else $error("timing mode not zero after reset");
  dqs_sync_a: assert property (dqs_oe |-> sync_active || $past(sync_active))
    else $error("strobe driven in async mode");
endmodule

// ===== verif/nrc_host_model.sv
// host controller model driving the nand pins
`timescale 1ns/100ps
module nrc_host_model (
  // clock
  input  wire logic  clk,
  // command and data pins
  output logic       target_sel_n,
  output logic       cmd_latch_en,
  output logic       addr_latch_en,
  output logic       write_clk,
  output logic       read_strobe_n,
  output logic       dqs_in,
  output logic [7:0] dq_in,
  // read sample point
  output logic       rd_take
);
  // idle levels at time zero
  initial begin
    target_sel_n  = 1'b1;
    cmd_latch_en  = 1'b0;
    addr_latch_en = 1'b0;
    write_clk     = 1'b1;
    read_strobe_n = 1'b1;
    dqs_in        = 1'b0;
    dq_in         = 8'h00;
    rd_take       = 1'b0;
  end
  // one latch cycle of 120 ns, write clock stands high outside it
  task automatic latch(input logic cle, input logic ale, input logic [7:0] b);
    target_sel_n  <= 1'b0;
    cmd_latch_en  <= cle;
    addr_latch_en <= ale;
    dq_in         <= b;
    write_clk     <= 1'b0;
    repeat (4) @(posedge clk);
    write_clk <= 1'b1;
    repeat (4) @(posedge clk);
    cmd_latch_en  <= 1'b0;
    addr_latch_en <= 1'b0;
    dq_in         <= ~b;  // released bus shows the inverse
    repeat (4) @(posedge clk);
  endtask
  // one data strobe cycle in sync mode, both latch enables high, sampled in the high phase
  task automatic read_dqs();
    cmd_latch_en  <= 1'b1;
    addr_latch_en <= 1'b1;
    dqs_in        <= 1'b1;
    repeat (3) @(posedge clk);
    rd_take <= 1'b1;
    @(posedge clk);
    rd_take <= 1'b0;
    dqs_in  <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // one read strobe cycle, sample point flagged late in the low phase
  task automatic read_byte();
    read_strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    rd_take <= 1'b1;
    @(posedge clk);
    rd_take       <= 1'b0;
    read_strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ===== verif/test_nrc_top.sv
// self-checking bench for the nand reset and identification block
`timescale 1ns/100ps
module test_nrc_top;
  import nrc_pkg::*;
  logic                clk, reset, target_sel_n, cmd_latch_en, addr_latch_en, write_clk, read_strobe_n;
  logic                dq_oe, dqs_in, dqs_out, dqs_oe, ready_busy_n, set_sync_mode, sync_active;
  logic                data_invalid, abort_ops, rd_take, sel;
  logic [7:0]          dq_in, dq_out, set_timing_mode, feature_param_one, fp;
  logic [NRC_DIES-1:0] die_busy, db_seen;
  logic [7:0]          exp_q[$];
  int                  fails = 0, total_checks = 0, cyc = 0, lo_len = 0, lo_cnt = 0;
  nrc_top #(.SYNC_CAPABLE(1'b1)) u_nrc_top (.clk(clk), .reset(reset), .target_sel_n(target_sel_n),
    .cmd_latch_en(cmd_latch_en), .addr_latch_en(addr_latch_en), .write_clk(write_clk),
    .read_strobe_n(read_strobe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe), .ready_busy_n(ready_busy_n), .set_sync_mode(set_sync_mode),
    .set_timing_mode(set_timing_mode), .sync_active(sync_active), .feature_param_one(feature_param_one),
    .data_invalid(data_invalid), .abort_ops(abort_ops), .die_busy(die_busy));
  nrc_host_model u_nrc_host_model (.clk(clk), .target_sel_n(target_sel_n), .cmd_latch_en(cmd_latch_en),
    .addr_latch_en(addr_latch_en), .write_clk(write_clk), .read_strobe_n(read_strobe_n),
    .dqs_in(dqs_in), .dq_in(dq_in), .rd_take(rd_take));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watcher: each read sample takes the oldest expected byte, or checks dq_oe low when none is left
  always @(posedge clk) begin
    if (rd_take === 1'b1) begin
      if (sync_active === 1'b1) chk_flag(dqs_oe && dqs_out, 1'b1);
      if (exp_q.size() == 0) chk_flag(dq_oe, 1'b0);
      else chk_byte(dq_out, exp_q.pop_front());
    end
  end
  // busy period length and dies seen busy
  always @(posedge clk) begin
    if (ready_busy_n === 1'b0) begin
      lo_cnt++;
      db_seen |= die_busy;
    end else if (lo_cnt > 0) begin
      lo_len = lo_cnt;
      lo_cnt = 0;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wait_busy();
    int n;
    n = 0;
    while (lo_len == 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic do_reset(input logic [7:0] op, input bit die, input logic s);
    lo_len  = 0;
    db_seen = '0;
    u_nrc_host_model.latch(1'b1, 1'b0, op);
    if (die) begin
      repeat (2) u_nrc_host_model.latch(1'b0, 1'b1, 8'h00);
      u_nrc_host_model.latch(1'b0, 1'b1, {7'h00, s});
    end
    wait_busy();
  endtask
  task automatic rd_cmd(input logic [7:0] op, input logic [7:0] adr, input int n);
    u_nrc_host_model.latch(1'b1, 1'b0, op);
    u_nrc_host_model.latch(1'b0, 1'b1, adr);
    repeat (n) u_nrc_host_model.read_byte();
  endtask
  // main sequence
  initial begin
    reset         = 1'b1;
    set_sync_mode = 1'b0;
    void'($urandom(32'h6cfe6beb));
    set_timing_mode = 8'($urandom_range(1, 5));
    sel             = 1'($urandom_range(0, 1));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    do_reset(NRC_OP_RESET, 1'b0, 1'b0); // first command after power-up
    chk_flag(lo_len >= RESET_CYC - 1 && lo_len <= RESET_CYC + 2, 1'b1);
    chk_flag(data_invalid, 1'b1);
    chk_flag(db_seen === '1, 1'b1);
    $display("test power-on reset done");
    exp_q = {NRC_ID_MAKER, NRC_ID_DEVICE, NRC_ID_BYTE2, NRC_ID_BYTE3, NRC_ID_BYTE4};
    rd_cmd(NRC_OP_IDENTIFY, NRC_ADR_MAKER, NRC_ID_LEN);
    exp_q = {NRC_SIG0, NRC_SIG1, NRC_SIG2, NRC_SIG3};
    rd_cmd(NRC_OP_IDENTIFY, NRC_ADR_SIG, 4);
    exp_q = {NRC_SIG0, NRC_SIG1, NRC_SIG2, NRC_SIG3, NRC_PP_REV_LO, NRC_PP_REV_HI,
             NRC_PP_FEAT_SYNC, NRC_PP_FEAT_HI, NRC_PP_OPT_LO, NRC_PP_OPT_HI};
    rd_cmd(NRC_OP_PARAM_PAGE, 8'h00, 10);
    $display("test identification reads done");
    fp = feature_param_one;
    do_reset(NRC_OP_RESET, 1'b0, 1'b0);
    chk_byte(feature_param_one, fp);
    u_nrc_host_model.latch(1'b1, 1'b0, NRC_OP_SYNC_RESET);
    repeat (20) @(posedge clk);
    chk_flag(ready_busy_n, 1'b1);
    $display("test async resets done");
    set_sync_mode <= 1'b1;
    repeat (4) @(posedge clk);
    set_sync_mode <= 1'b0;
    repeat (4) @(posedge clk);
    chk_flag(sync_active, 1'b1);
    exp_q = {NRC_SIG0, NRC_SIG1, NRC_SIG2, NRC_SIG3};
    u_nrc_host_model.latch(1'b1, 1'b0, NRC_OP_IDENTIFY);
    u_nrc_host_model.latch(1'b0, 1'b1, NRC_ADR_SIG);
    repeat (4) u_nrc_host_model.read_dqs();
    $display("test synchronous identification done");
    do_reset(NRC_OP_SYNC_RESET, 1'b0, 1'b0);
    chk_flag(lo_len >= RESET_CYC - 1 && lo_len <= RESET_CYC + 2, 1'b1);
    chk_flag(sync_active && db_seen === '1, 1'b1);
    do_reset(NRC_OP_DIE_RESET, 1'b1, sel); // die reset right after a sync reset, only the selected die goes busy
    chk_flag(db_seen === 2'(1 << sel), 1'b1);
    chk_flag(sync_active, 1'b1);
    do_reset(NRC_OP_RESET, 1'b0, 1'b0); // nothing issued until ready again
    chk_flag(sync_active, 1'b0);
    chk_byte(feature_param_one, NRC_TM_ASYNC0);
    $display("test sync resets done");
    lo_len = 0;
    u_nrc_host_model.latch(1'b1, 1'b0, NRC_OP_RESET);
    rd_cmd(NRC_OP_IDENTIFY, NRC_ADR_MAKER, 0);
    wait_busy();
    u_nrc_host_model.read_byte();
    $display("test identify while busy done");
    wrap_up();
  end
endmodule
bind nrc_top nrc_top_chk u_nrc_top_chk (.clk(clk), .reset(reset), .ready_busy_n(ready_busy_n),
  .abort_ops(abort_ops), .data_invalid(data_invalid), .dq_oe(dq_oe), .dqs_oe(dqs_oe),
  .sync_active(sync_active), .feature_param_one(feature_param_one), .die_busy(die_busy));
